// >>> core/rsq_regs.svh
// register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

// register byte offsets
`define RSQ_OFF_CTRL_STATUS 32'h0000_0000
`define RSQ_OFF_OPT_STATUS  32'h0000_0004

// integrity_ctrl_status bit positions
`define RSQ_BIT_AUX_SRC     7
`define RSQ_BIT_AUX_IE      6
`define RSQ_BIT_AUX_FLAG    5
`define RSQ_BIT_UV_RF       4
`define RSQ_BIT_CSS_IE      2
`define RSQ_BIT_SAFE_OSC    1
`define RSQ_BIT_WDG_RF      0
`define RSQ_CTRL_RESET      8'h00

// option status layout: options in the low byte, sequencer state above
`define RSQ_OPT_STATE_LSB   8

// timing
`define RSQ_CLK_NS          10
`define RSQ_DLY_SHORT_CYC   256
`define RSQ_DLY_LONG_CYC    4096
`define RSQ_FETCH_CYC       2
`define RSQ_TW_OUT_NS       500
`define RSQ_TW_OUT_CYC      ((`RSQ_TW_OUT_NS + `RSQ_CLK_NS - 1) / `RSQ_CLK_NS)
`define RSQ_CSS_FILT_CYC    8
`define RSQ_SETTLE_CYC      3

// reset vector, low byte address first
`define RSQ_VEC_ADDR        16'hfffe

`endif

// >>> core/rsq_pkg.sv
// types shared by the reset sequencer
package rsq_pkg;

	// sequencer phases, one-hot
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'b0001,
		ST_DELAY  = 4'b0010,
		ST_FETCH  = 4'b0100,
		ST_RUN    = 4'b1000
	} rsq_state_e;

	// non-volatile options, sampled while in reset
	typedef struct packed {
		logic       css_en;
		logic [1:0] uv_level;
		logic       uv_en;
		logic       long_delay;
	} rsq_opt_s;

	// analog comparator and oscillator status inputs
	typedef struct packed {
		logic osc_ok;
		logic aux_evd;
		logic aux_vdd;
		logic below_lo;
		logic below_hi;
	} rsq_ana_s;

endpackage : rsq_pkg

// >>> core/rsq_top.sv
// reset sequencer with supply monitor, auxiliary detector and clock security
//
// Function
// - external pin, undervoltage and watchdog expiry all start one reset sequence
// - every cause pulls the reset pin low, held low through the delay
// - processor start address is fetched from the top two bytes
// - sequence runs active phase, counted delay, then vector fetch
// - delay is 256 or 4096 cycles, chosen by option sampled at reset
// - vector fetch lasts exactly two cycles
// - external low pulse is caught asynchronously, even with clocks stopped
// - recognised external pulse is stretched to the minimum output width
// - watchdog underflow drives the pin low for the minimum width
// - undervoltage holds reset below upper threshold rising, lower falling
// - undervoltage threshold is low, medium or high by option
// - undervoltage detector is enabled or disabled by option
// - auxiliary flag is read-only and follows the comparator directly
// - auxiliary detector works only with undervoltage detector enabled
// - source select clear: aux monitors supply with level-tied thresholds
// - source select set: aux monitors the external detect pin
// - supply mode: interrupt on each aux flag toggle when enabled
// - no aux interrupt for a rise completing inside the reset delay
// - enabling while below threshold gives one interrupt, crossing another
// - enabling after the crossing gives only one interrupt
// - pin mode: interrupt on both comparator edges when enabled
// - clock security filters main clock and swaps to backup on loss
// - safe oscillator flag set while active, cleared by read after recovery
// - reset cause flags: undervoltage first, watchdog second, pin neither
// - pending aux interrupt clears on entry to its service routine
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rsq_regs.svh"

module rsq_top (
	// clock and bus reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// open-drain reset pin, oe low means pin pulled low
	input  wire logic              rst_pin_i,
	output logic                   rst_pin_o,
	output logic                   rst_pin_oe_n,
	// asynchronous option straps and analog status
	input  wire rsq_pkg::rsq_opt_s opt_i,
	input  wire rsq_pkg::rsq_ana_s ana_i,
	// watchdog underflow pulse and aux interrupt acknowledge
	input  wire logic              wdg_underflow,
	input  wire logic              aux_irq_ack,
	// processor side
	output logic                   cpu_rst_n,
	output logic                   vec_fetch,
	output logic      [15:0]       vec_addr,
	output logic                   aux_irq,
	output logic                   css_irq,
	// analog controls
	output logic      [1:0]        uv_level,
	output logic                   safe_osc_sel
);

	localparam int SW = 11;
	localparam logic [7:0]  TW_LAST    = 8'(`RSQ_TW_OUT_CYC - 1);
	localparam logic [11:0] DLY_S_LAST = 12'(`RSQ_DLY_SHORT_CYC - 1);
	localparam logic [11:0] DLY_L_LAST = 12'(`RSQ_DLY_LONG_CYC - 1);
	localparam logic [3:0]  FILT_LAST  = 4'(`RSQ_CSS_FILT_CYC - 1);

	rsq_pkg::rsq_state_e state_q;
	rsq_pkg::rsq_opt_s   opt_s, opt_q;
	rsq_pkg::rsq_ana_s   ana_s;
	logic [SW-1:0] sync1_q, sync2_q;
	logic          ext_seen_q, ext_s;
	logic [7:0]    act_cnt_q;
	logic [11:0]   dly_cnt_q;
	logic          fetch_cnt_q;
	logic [1:0]    settle_q;
	logic          uv_low_q;
	logic          aux_src_q, aux_ie_q, aux_ie_prev_q, aux_flag_q, aux_prev_q, aux_pend_q;
	logic          uv_rf_q, wdg_rf_q, css_ie_q, safe_flag_q, safe_sel_q, css_irq_q;
	logic [3:0]    filt_q;
	logic          oe_n_q, cpu_rst_n_q, vec_fetch_q, pin_o_q;
	logic [15:0]   vec_addr_q;
	logic [31:0]   prdata_q;
	logic          pready_q, pslverr_q;
	logic          act_done, dly_done, cause_hold, cause_run, apb_wr, apb_rd, hit_ctrl, hit_opt;
	logic          aux_toggle, aux_set;
	logic [11:0]   dly_last;
	logic [7:0]    ctrl_rd;

	////////////////////////////////////////////////////////////////////////////
	// external pin capture and synchronisers

	// async set so a pulse is caught with the clock stopped; cleared only
	// while the pin is released during fetch
	always_ff @(posedge pclk or negedge presetn or negedge rst_pin_i) begin
		if (!presetn)
			ext_seen_q <= 1'b0;
		else if (!rst_pin_i)
			ext_seen_q <= 1'b1;
		else if (state_q == rsq_pkg::ST_FETCH)
			ext_seen_q <= 1'b0;
	end

	// two-flop synchroniser for every asynchronous input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {ext_seen_q, opt_i, ana_i};
			sync2_q <= sync1_q;
		end
	end

	assign ext_s = sync2_q[SW-1];
	assign opt_s = rsq_pkg::rsq_opt_s'(sync2_q[9:5]);
	assign ana_s = rsq_pkg::rsq_ana_s'(sync2_q[4:0]);

	////////////////////////////////////////////////////////////////////////////
	// options and undervoltage hysteresis

	// options read from opt_q are only taken in the active phase so they never change under software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			opt_q <= '0;
		else if (state_q == rsq_pkg::ST_ACTIVE)
			opt_q <= opt_s;
	end

	// powers up assuming low supply until the comparators or a disabled detector show otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			uv_low_q <= 1'b1;
		else if (!opt_s.uv_en)
			uv_low_q <= 1'b0;
		else if (ana_s.below_lo)
			uv_low_q <= 1'b1;
		else if (!ana_s.below_hi)
			uv_low_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// reset sequencer

	assign act_done   = (act_cnt_q == TW_LAST);
	assign dly_last   = opt_q.long_delay ? DLY_L_LAST : DLY_S_LAST;
	assign dly_done   = (dly_cnt_q == dly_last);
	assign cause_hold = uv_low_q | wdg_underflow;
	// own drive echoes on the pin, so the pin counts only after it settles
	assign cause_run  = cause_hold | (ext_s & (settle_q == 2'(`RSQ_SETTLE_CYC)));

	// phase sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_q <= rsq_pkg::ST_ACTIVE;
		else begin
			case (state_q)
				rsq_pkg::ST_ACTIVE: begin
					if (act_done && !uv_low_q)
						state_q <= rsq_pkg::ST_DELAY;
				end
				rsq_pkg::ST_DELAY: begin
					if (uv_low_q)
						state_q <= rsq_pkg::ST_ACTIVE;
					else if (dly_done && !wdg_underflow)
						state_q <= rsq_pkg::ST_FETCH;
				end
				rsq_pkg::ST_FETCH: begin
					if (cause_hold)
						state_q <= rsq_pkg::ST_ACTIVE;
					else if (fetch_cnt_q)
						state_q <= rsq_pkg::ST_RUN;
				end
				rsq_pkg::ST_RUN: begin
					if (cause_run)
						state_q <= rsq_pkg::ST_ACTIVE;
				end
				default: state_q <= rsq_pkg::ST_ACTIVE;
			endcase
		end
	end

	// minimum output pulse width count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			act_cnt_q <= '0;
		else if (state_q != rsq_pkg::ST_ACTIVE)
			act_cnt_q <= '0;
		else if (!act_done)
			act_cnt_q <= act_cnt_q + 8'h01;
	end

	// stabilisation delay count, restarted by undervoltage or watchdog underflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dly_cnt_q <= '0;
		else if (state_q != rsq_pkg::ST_DELAY || cause_hold)
			dly_cnt_q <= '0;
		else if (!dly_done)
			dly_cnt_q <= dly_cnt_q + 12'h001;
	end

	// fetch cycle and settle counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_cnt_q <= 1'b0;
			settle_q    <= '0;
		end else begin
			fetch_cnt_q <= (state_q == rsq_pkg::ST_FETCH) ? ~fetch_cnt_q : 1'b0;
			if (state_q != rsq_pkg::ST_RUN)
				settle_q <= '0;
			else if (settle_q != 2'(`RSQ_SETTLE_CYC))
				settle_q <= settle_q + 2'h1;
		end
	end

	// pin drive, processor reset and vector fetch, all registered from the current state, one cycle behind it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_n_q      <= 1'b0;
			cpu_rst_n_q <= 1'b0;
			vec_fetch_q <= 1'b0;
			vec_addr_q  <= `RSQ_VEC_ADDR;
			pin_o_q     <= 1'b0;
		end else begin
			pin_o_q     <= 1'b0;
			// enable kept active low in the flop so the pin output needs no gate
			oe_n_q      <= !((state_q == rsq_pkg::ST_ACTIVE) ||
				(state_q == rsq_pkg::ST_DELAY));
			cpu_rst_n_q <= (state_q == rsq_pkg::ST_RUN);
			vec_fetch_q <= (state_q == rsq_pkg::ST_FETCH);
			vec_addr_q  <= `RSQ_VEC_ADDR | {15'h0000, fetch_cnt_q};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// auxiliary voltage detector

	// flag follows the chosen comparator, idle while the detector is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			aux_flag_q <= 1'b0;
		else if (!opt_q.uv_en)
			aux_flag_q <= 1'b0;
		else
			aux_flag_q <= aux_src_q ? ana_s.aux_evd : ana_s.aux_vdd;
	end

	assign aux_toggle = aux_flag_q ^ aux_prev_q;
	// history tracks through reset so a rise inside the delay raises nothing
	assign aux_set = (state_q == rsq_pkg::ST_RUN) && aux_ie_q &&
		(aux_toggle || (!aux_ie_prev_q && aux_flag_q));

	// pending aux request, a new event beats the acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_prev_q    <= 1'b0;
			aux_ie_prev_q <= 1'b0;
			aux_pend_q    <= 1'b0;
		end else begin
			aux_prev_q    <= aux_flag_q;
			aux_ie_prev_q <= aux_ie_q;
			if (aux_set)
				aux_pend_q <= 1'b1;
			else if (aux_irq_ack || state_q != rsq_pkg::ST_RUN)
				aux_pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock security

	// loss or recovery must persist for the filter length, so spikes pass unseen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_q     <= '0;
			safe_sel_q <= 1'b0;
		end else if (!opt_q.css_en) begin
			filt_q     <= '0;
			safe_sel_q <= 1'b0;
		end else if (ana_s.osc_ok == safe_sel_q) begin
			if (filt_q == FILT_LAST) begin
				filt_q     <= '0;
				safe_sel_q <= ~safe_sel_q;
			end else
				filt_q <= filt_q + 4'h1;
		end else
			filt_q <= '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state so read data comes from a flop

	assign hit_ctrl = (paddr == `RSQ_OFF_CTRL_STATUS);
	assign hit_opt  = (paddr == `RSQ_OFF_OPT_STATUS);
	assign apb_wr   = psel && penable && pready_q && pwrite && hit_ctrl;
	assign apb_rd   = psel && penable && pready_q && !pwrite && hit_ctrl;

	always_comb begin
		ctrl_rd = `RSQ_CTRL_RESET;
		ctrl_rd[`RSQ_BIT_AUX_SRC]  = aux_src_q;
		ctrl_rd[`RSQ_BIT_AUX_IE]   = aux_ie_q;
		ctrl_rd[`RSQ_BIT_AUX_FLAG] = aux_flag_q;
		ctrl_rd[`RSQ_BIT_UV_RF]    = uv_rf_q;
		ctrl_rd[`RSQ_BIT_CSS_IE]   = css_ie_q;
		ctrl_rd[`RSQ_BIT_SAFE_OSC] = safe_flag_q;
		ctrl_rd[`RSQ_BIT_WDG_RF]   = wdg_rf_q;
	end

	// bus handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !hit_ctrl && !hit_opt;
			if (psel && penable && !pready_q)
				prdata_q <= hit_ctrl ? {24'h000000, ctrl_rd} :
					hit_opt ? {20'h00000, state_q, 3'h0, opt_q} : 32'h0000_0000;
		end
	end

	// software control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_src_q <= 1'b0;
			aux_ie_q  <= 1'b0;
			css_ie_q  <= 1'b0;
		end else if (apb_wr) begin
			aux_src_q <= pwdata[`RSQ_BIT_AUX_SRC];
			aux_ie_q  <= pwdata[`RSQ_BIT_AUX_IE];
			css_ie_q  <= pwdata[`RSQ_BIT_CSS_IE];
		end
	end

	// reset cause flags; set on sequence start beats a software zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_rf_q  <= 1'b0;
			wdg_rf_q <= 1'b0;
		end else if (state_q != rsq_pkg::ST_ACTIVE && uv_low_q) begin
			uv_rf_q  <= 1'b1;
			wdg_rf_q <= 1'b0;
		end else if (state_q == rsq_pkg::ST_RUN && wdg_underflow) begin
			wdg_rf_q <= 1'b1;
			if (apb_wr && !pwdata[`RSQ_BIT_UV_RF])
				uv_rf_q <= 1'b0;
		end else if (apb_wr) begin
			if (!pwdata[`RSQ_BIT_UV_RF])
				uv_rf_q <= 1'b0;
			if (!pwdata[`RSQ_BIT_WDG_RF])
				wdg_rf_q <= 1'b0;
		end
	end

	// safe oscillator flag: set wins, cleared by a read once recovered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			safe_flag_q <= 1'b0;
			css_irq_q   <= 1'b0;
		end else begin
			if (safe_sel_q)
				safe_flag_q <= 1'b1;
			else if (apb_rd)
				safe_flag_q <= 1'b0;
			css_irq_q <= css_ie_q && safe_flag_q;
		end
	end

	// outputs
	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign rst_pin_o    = pin_o_q;
	assign rst_pin_oe_n = oe_n_q;
	assign cpu_rst_n    = cpu_rst_n_q;
	assign vec_fetch    = vec_fetch_q;
	assign vec_addr     = vec_addr_q;
	assign aux_irq      = aux_pend_q;
	assign css_irq      = css_irq_q;
	assign uv_level     = opt_q.uv_level;
	assign safe_osc_sel = safe_sel_q;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_fetch_pair;
		vec_fetch && vec_addr == 16'hfffe ##1 vec_fetch && vec_addr == 16'hffff;
	endsequence

	sequence s_enter_fetch;
		state_q == rsq_pkg::ST_DELAY && dly_done && !cause_hold;
	endsequence

	a_pin_held_low:
		assert property (state_q == rsq_pkg::ST_DELAY |=> !rst_pin_oe_n)
		else $error("reset pin released during delay");
	a_vector_fetch:
		assert property ($rose(vec_fetch) |-> s_fetch_pair ##1 !vec_fetch)
		else $error("vector fetch not two cycles at top addresses");
	a_fetch_length:
		assert property (s_enter_fetch |=> state_q == rsq_pkg::ST_FETCH [*2]
			##1 state_q inside {rsq_pkg::ST_RUN, rsq_pkg::ST_ACTIVE})
		else $error("fetch phase length wrong");
	a_delay_count:
		assert property (state_q == rsq_pkg::ST_FETCH && $past(state_q) == rsq_pkg::ST_DELAY
			|-> $past(dly_cnt_q) == (opt_q.long_delay ? 12'hfff : 12'h0ff))
		else $error("delay length does not match option");
	a_delay_restart:
		assert property (state_q == rsq_pkg::ST_DELAY && wdg_underflow && !uv_low_q
			|=> dly_cnt_q == 12'h000)
		else $error("delay not restarted");
	a_wdg_reset:
		assert property (state_q == rsq_pkg::ST_RUN && wdg_underflow
			|=> state_q == rsq_pkg::ST_ACTIVE ##1 !rst_pin_oe_n && wdg_rf_q)
		else $error("watchdog did not start reset");
	a_active_width:
		assert property (state_q == rsq_pkg::ST_ACTIVE && $past(state_q) == rsq_pkg::ST_ACTIVE
			&& !$stable(act_cnt_q) |-> act_cnt_q <= TW_LAST)
		else $error("active counter overran");
	a_leave_active:
		assert property ($fell(state_q == rsq_pkg::ST_ACTIVE) |-> $past(act_done))
		else $error("active phase shorter than minimum width");
	a_aux_off:
		assert property (!opt_q.uv_en |=> !aux_flag_q)
		else $error("aux flag active with detector off");
	a_aux_irq:
		assert property (aux_ie_q && aux_toggle && state_q == rsq_pkg::ST_RUN |=> aux_irq)
		else $error("aux toggle gave no request");
	a_uv_flags:
		assert property (state_q == rsq_pkg::ST_RUN && uv_low_q |=> uv_rf_q && !wdg_rf_q)
		else $error("undervoltage cause not recorded");

endmodule : rsq_top

// >>> tb/rsq_ext_reset.sv
// board-side reset circuitry sharing the open-drain reset line
`timescale 1ns/1ps

module rsq_ext_reset (
	// clock for pulse timing
	input  wire logic       pclk,
	// pulse request from the bench
	input  wire logic       go,
	input  wire logic [7:0] len,
	// device side of the open-drain pin
	input  wire logic       dev_o,
	input  wire logic       dev_oe_n,
	// resolved line level
	output logic            pin_lvl
);
	logic [7:0] cnt_q;

	initial cnt_q = 8'h00;

	// holds the line low for len cycles, short pulses are the point
	always @(posedge pclk) begin
		if (go) begin
			cnt_q <= len;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// wired-and with weak pull-up, a released line returns high
	assign pin_lvl = (cnt_q == 8'h00) & (dev_oe_n | dev_o);
endmodule : rsq_ext_reset

// >>> tb/rsq_bench.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`include "rsq_regs.svh"

module reset_sequence_and_supply_monitor_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go;
	logic rst_pin_i, rst_pin_o, rst_pin_oe_n, wdg_underflow, aux_irq_ack;
	logic cpu_rst_n, vec_fetch, aux_irq, css_irq, safe_osc_sel;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [15:0] vec_addr;
	logic [15:0] va [2];
	logic [1:0]  uv_level;
	logic [7:0]  len;
	rsq_pkg::rsq_opt_s opt;
	rsq_pkg::rsq_ana_s ana;
	int n_mismatch, n_tests, fn;

	rsq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
		.rst_pin_oe_n(rst_pin_oe_n), .opt_i(opt), .ana_i(ana), .wdg_underflow(wdg_underflow),
		.aux_irq_ack(aux_irq_ack), .cpu_rst_n(cpu_rst_n), .vec_fetch(vec_fetch),
		.vec_addr(vec_addr), .aux_irq(aux_irq), .css_irq(css_irq), .uv_level(uv_level),
		.safe_osc_sel(safe_osc_sel));
	rsq_ext_reset u_ext (.pclk(pclk), .go(go), .len(len), .dev_o(rst_pin_o),
		.dev_oe_n(rst_pin_oe_n), .pin_lvl(rst_pin_i));

	always #5 pclk = ~pclk;

	// logs fetch cycles so their alignment to pin release does not matter
	always @(negedge pclk) begin
		if (vec_fetch === 1'b1) begin
			if (fn < 2) va[fn] = vec_addr;
			fn++;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		n_tests++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_rng

	task automatic cyc(input int n);
		repeat (n) @(negedge pclk);
	endtask : cyc

	// one apb transfer, request held until pready is seen high
	// answer taken at the rising edge that sees pready, only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// measures the pin-low span and the vector fetch that follows
	task automatic seq(input int lo, input int hi);
		int n;
		n = 0;
		fn = 0;
		while (rst_pin_oe_n !== 1'b0 && n < 20) begin
			@(negedge pclk);
			n++;
		end
		n = 0;
		while (rst_pin_oe_n === 1'b0 && n < 6000) begin
			@(negedge pclk);
			n++;
		end
		chk_rng("pin low cycles", lo, hi, n);
		cyc(6);
		chk("fetch cycles", 32'h2, fn);
		chk("vector first", {16'h0000, `RSQ_VEC_ADDR}, va[0]);
		chk("vector second", 32'h0000_ffff, va[1]);
		chk("cpu run", 1'b1, cpu_rst_n);
	endtask : seq

	// one-cycle pulse on the watchdog line (w high) or the aux acknowledge
	task automatic pulse(input logic w);
		@(posedge pclk);
		if (w)
			wdg_underflow <= 1'b1;
		else
			aux_irq_ack <= 1'b1;
		@(posedge pclk);
		wdg_underflow <= 1'b0;
		aux_irq_ack <= 1'b0;
		@(negedge pclk);
	endtask : pulse

	task automatic ack;
		pulse(1'b0);
		chk("aux irq cleared", 1'b0, aux_irq);
	endtask : ack

	task automatic irq_is(input logic e);
		cyc(8);
		chk("aux irq", e, aux_irq);
	endtask : irq_is

	////////////////////////////////////////////////////////////////////////
	task automatic t_boot;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		seq(50 + `RSQ_DLY_SHORT_CYC, 62 + `RSQ_DLY_SHORT_CYC);
		$display("done power-up");
	endtask : t_boot

	task automatic t_map;
		chk("pin data", 1'b0, rst_pin_o);
		apb(1'b0, 32'h8, 32'h0);
		chk("unmapped error", 1'b1, err);
		apb(1'b1, `RSQ_OFF_OPT_STATUS, 32'h0);
		apb(1'b0, `RSQ_OFF_OPT_STATUS, 32'h0);
		chk("option status", 32'h0000_081a, rd);
		chk("uv level", opt.uv_level, uv_level);
		$display("done map");
	endtask : t_map

	task automatic t_wdg;
		@(posedge pclk);
		opt.long_delay <= 1'b1;
		pulse(1'b1);
		seq(50 + `RSQ_DLY_LONG_CYC, 62 + `RSQ_DLY_LONG_CYC);
		apb(1'b0, `RSQ_OFF_CTRL_STATUS, 32'h0);
		chk("wdg cause", 32'h1, rd & 32'h11);
		$display("done watchdog");
	endtask : t_wdg

	task automatic t_uv;
		@(posedge pclk);
		opt.long_delay <= 1'b0;
		ana.below_hi <= 1'b1;
		cyc(20);
		chk("upper only in run", 1'b1, rst_pin_oe_n);
		@(posedge pclk) ana.below_lo <= 1'b1;
		cyc(80);
		chk("below lower", 1'b0, rst_pin_oe_n);
		@(posedge pclk) ana.below_lo <= 1'b0;
		cyc(80);
		chk("below upper rising", 1'b0, rst_pin_oe_n);
		@(posedge pclk) ana.below_hi <= 1'b0;
		cyc(150);
		// a real drop inside the delay: both comparators trip, hysteresis needs the lower one
		@(posedge pclk) ana.below_hi <= 1'b1;
		ana.below_lo <= 1'b1;
		cyc(6);
		@(posedge pclk) ana.below_hi <= 1'b0;
		ana.below_lo <= 1'b0;
		seq(`RSQ_DLY_SHORT_CYC, 70 + `RSQ_DLY_SHORT_CYC);
		apb(1'b0, `RSQ_OFF_CTRL_STATUS, 32'h0);
		chk("uv cause", 32'h10, rd & 32'h10);
		apb(1'b1, `RSQ_OFF_CTRL_STATUS, 32'h0);
		$display("done undervoltage");
	endtask : t_uv

	task automatic t_ext;
		@(posedge pclk);
		len <= 8'h05;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		seq(50 + `RSQ_DLY_SHORT_CYC, 62 + `RSQ_DLY_SHORT_CYC);
		apb(1'b0, `RSQ_OFF_CTRL_STATUS, 32'h0);
		chk("pin cause", 32'h0, rd & 32'h11);
		$display("done pin");
	endtask : t_ext

	task automatic t_aux;
		apb(1'b1, `RSQ_OFF_CTRL_STATUS, 32'h40);
		irq_is(1'b0);
		@(posedge pclk) ana.aux_vdd <= 1'b1;
		irq_is(1'b1);
		apb(1'b0, `RSQ_OFF_CTRL_STATUS, 32'h0);
		chk("aux flag", 32'h20, rd & 32'h20);
		ack;
		@(posedge pclk) ana.aux_vdd <= 1'b0;
		irq_is(1'b1);
		ack;
		apb(1'b1, `RSQ_OFF_CTRL_STATUS, 32'h0);
		@(posedge pclk) ana.aux_vdd <= 1'b1;
		irq_is(1'b0);
		apb(1'b1, `RSQ_OFF_CTRL_STATUS, 32'h40);
		irq_is(1'b1);
		ack;
		apb(1'b1, `RSQ_OFF_CTRL_STATUS, 32'he0);
		cyc(8);
		ack;
		apb(1'b0, `RSQ_OFF_CTRL_STATUS, 32'h0);
		chk("pin source", 32'hc0, rd & 32'he0);
		@(posedge pclk) ana.aux_evd <= 1'b1;
		irq_is(1'b1);
		ack;
		@(posedge pclk) ana.aux_evd <= 1'b0;
		irq_is(1'b1);
		ack;
		@(posedge pclk) ana.aux_vdd <= 1'b0;
		irq_is(1'b0);
		$display("done aux");
	endtask : t_aux

	task automatic t_css;
		apb(1'b1, `RSQ_OFF_CTRL_STATUS, 32'h04);
		@(posedge pclk) ana.osc_ok <= 1'b0;
		cyc(20);
		chk("backup selected", 1'b1, safe_osc_sel);
		chk("css irq", 1'b1, css_irq);
		@(posedge pclk) ana.osc_ok <= 1'b1;
		cyc(20);
		chk("main restored", 1'b0, safe_osc_sel);
		apb(1'b0, `RSQ_OFF_CTRL_STATUS, 32'h0);
		chk("safe flag held", 32'h2, rd & 32'h2);
		apb(1'b0, `RSQ_OFF_CTRL_STATUS, 32'h0);
		chk("safe flag read clear", 32'h0, rd & 32'h2);
		$display("done clock security");
	endtask : t_css

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	// main sequence, inputs all defined at time zero
	initial begin
		{pclk, presetn, psel, penable, pwrite, go, wdg_underflow, aux_irq_ack} = 8'h00;
		{paddr, pwdata, len} = 72'h0;
		opt = 5'h1a;
		ana = 5'h10;
		n_mismatch = 0;
		n_tests = 0;
		fn = 0;
		t_boot;
		t_map;
		t_wdg;
		t_uv;
		t_ext;
		t_aux;
		t_css;
		wrap_up;
	end

	// the run needs about 6000 cycles, so 20000 means a hang
	initial begin
		#200000;
		n_mismatch++;
		wrap_up;
	end
endmodule : reset_sequence_and_supply_monitor_bench
